// ==== verilog/epc_pkg.sv ====
/*
 * Constants, field layouts and types for the array programming control and option decoder.
 * Assumes a classic Wishbone master with 32-bit data and the array reached over plain ports.
 */
package epc_pkg;

    // ****************************************
    // Register map, as word indices.
    // ****************************************
    localparam logic [12:0] EPC_IDX_CTL = 13'h001c;
    localparam logic [12:0] EPC_IDX_OPT_UP = 13'h1eff;
    localparam logic [12:0] EPC_IDX_OPT_LO = 13'h1f00;
    localparam int EPC_UNMAP_BIT = 15;
    localparam logic [7:0] EPC_CTL_RST = 8'h00;
    localparam logic [7:0] EPC_OPT_RST = 8'h00;

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int EPC_BIT_PG = 0;
    localparam int EPC_BIT_LAT = 2;
    localparam int EPC_OPT_WD = 0;
    localparam int EPC_OPT_LEVEL = 1;
    localparam int EPC_OPT_LSB_FIRST = 2;
    localparam int EPC_OPT_RATE_LO = 3;
    localparam int EPC_OPT_RATE_HI = 4;
    localparam int EPC_OPT_STOP = 5;
    localparam int EPC_OPT_SECURE = 7;

    // ****************************************
    // Serial clock divisors and boot patterns.
    // ****************************************
    localparam logic [6:0] EPC_DIV_64 = 7'h40;
    localparam logic [6:0] EPC_DIV_32 = 7'h20;
    localparam logic [6:0] EPC_DIV_16 = 7'h10;
    localparam logic [6:0] EPC_DIV_8 = 7'h08;
    localparam logic [2:0] EPC_PAT_PROG = 3'h7;
    localparam logic [2:0] EPC_PAT_VERIFY = 3'h6;
    localparam logic [2:0] EPC_PAT_DUMP = 3'h4;

    typedef enum logic [1:0] {
        EPC_BOOT_NONE = 2'b00,
        EPC_BOOT_PROG_VERIFY = 2'b01,
        EPC_BOOT_VERIFY = 2'b10,
        EPC_BOOT_DUMP = 2'b11
    } epc_boot_t;

    typedef enum logic [1:0] {
        EPC_ST_LOAD_UP = 2'b00,
        EPC_ST_LOAD_LO = 2'b01,
        EPC_ST_RUN = 2'b10
    } epc_st_t;

endpackage

// ==== verilog/epc_top.sv ====
/*
 * Programming control register, array access path and option byte decoder.
 * Assumes a classic Wishbone master and an array whose read data is valid in the
 * same cycle that its read strobe and address are driven.
 */
`timescale 1ns/100ps
module epc_top
    import epc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [12:0] arr_addr_o,
    output logic arr_rd_o,
    input wire logic [7:0] arr_rdata_i,
    output logic [12:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic prog_valid_o,
    output logic prog_latch_o,
    output logic prog_power_o,
    input wire logic boot_select_high_i,
    input wire logic boot_select_mid_i,
    input wire logic boot_select_low_i,
    input wire logic boot_source_select_i,
    output epc_boot_t boot_mode_o,
    output logic boot_ext_src_o,
    input wire logic wd_timeout_i,
    input wire logic irq_pin_normal_i,
    output logic wd_reset_o,
    input wire logic irq_n_i,
    output logic irq_req_o,
    input wire logic [7:0] key_pins_i,
    output logic [7:0] key_pullup_options_o,
    output logic [7:0] key_irq_o,
    output logic lsb_first_o,
    output logic serial_tick_o,
    input wire logic stop_req_i,
    output logic halt_mode_o,
    output logic osc_stop_o,
    output logic secure_lock_o
);

    // ****************************************
    // Serial divisor decode.
    // ****************************************
    function automatic logic [6:0] epc_div(input logic [1:0] code);
        unique case (code)
            2'b00: epc_div = EPC_DIV_64;
            2'b01: epc_div = EPC_DIV_32;
            2'b10: epc_div = EPC_DIV_16;
            2'b11: epc_div = EPC_DIV_8;
        endcase
    endfunction

    epc_st_t st_r;
    epc_st_t st_nxt;
    logic lat_r;
    logic pg_r;
    logic pend_r;
    logic ack_r;
    logic [7:0] dat_r;
    logic cap_valid_r;
    logic [12:0] cap_addr_r;
    logic [7:0] cap_data_r;
    logic [7:0] opt_up_r;
    logic [7:0] opt_lo_r;
    epc_boot_t boot_r;
    logic ext_src_r;
    logic irq_prev_r;
    logic irq_r;
    logic [7:0] key_prev_r;
    logic [7:0] key_irq_r;
    logic wd_r;
    logic halt_r;
    logic osc_stop_r;
    logic [6:0] div_cnt_r;
    logic tick_r;

    // ****************************************
    // Bus decode.
    // ****************************************
    wire run = (st_r == EPC_ST_RUN);
    wire [12:0] idx = wb_adr_i[14:2];
    wire unmapped = wb_adr_i[EPC_UNMAP_BIT];
    wire is_ctl = !unmapped && (idx == EPC_IDX_CTL);
    wire is_arr = !unmapped && !is_ctl;
    wire req = wb_cyc_i && wb_stb_i && !pend_r && !ack_r && run;
    wire done = wb_cyc_i && wb_stb_i && ack_r;
    wire wr_done = done && wb_we_i && wb_sel_i[0];
    wire ctl_wr = wr_done && is_ctl;
    wire arr_wr = wr_done && is_arr && lat_r;
    wire bus_rd = pend_r && !wb_we_i && is_arr && !lat_r;
    wire [7:0] ctl_val = {5'h00, lat_r, 1'b0, pg_r};
    wire [7:0] rd_val = is_ctl ? ctl_val : (bus_rd ? arr_rdata_i : 8'h00);

    // Control bit interlocks: gate power only over an already set latch.
    wire lat_nxt = ctl_wr ? wb_dat_i[EPC_BIT_LAT] : lat_r;
    wire pg_nxt = ctl_wr ? (wb_dat_i[EPC_BIT_PG] && lat_r && wb_dat_i[EPC_BIT_LAT]) : pg_r;

    // ****************************************
    // Option decode.
    // ****************************************
    wire [2:0] boot_pat = {boot_select_high_i, boot_select_mid_i, boot_select_low_i};
    wire [1:0] rate = {opt_lo_r[EPC_OPT_RATE_HI], opt_lo_r[EPC_OPT_RATE_LO]};
    wire [6:0] div_val = epc_div(rate);
    wire div_end = (div_cnt_r == div_val - 7'h01);
    wire level_mode = opt_lo_r[EPC_OPT_LEVEL];
    wire irq_nxt = (irq_prev_r && !irq_n_i) || (level_mode && !irq_n_i);
    wire [7:0] key_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_key
            assign key_nxt[gi] = opt_up_r[gi] &&
                ((key_prev_r[gi] && !key_pins_i[gi]) || (level_mode && !key_pins_i[gi]));
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            EPC_ST_LOAD_UP: st_nxt = EPC_ST_LOAD_LO;
            EPC_ST_LOAD_LO: st_nxt = EPC_ST_RUN;
            EPC_ST_RUN: st_nxt = EPC_ST_RUN;
            default: st_nxt = EPC_ST_LOAD_UP;
        endcase
    end

    // ****************************************
    // Array port.
    // ****************************************
    assign arr_addr_o = (st_r == EPC_ST_LOAD_UP) ? EPC_IDX_OPT_UP :
                        (st_r == EPC_ST_LOAD_LO) ? EPC_IDX_OPT_LO : idx;
    assign arr_rd_o = !run || bus_rd;

    // ****************************************
    // Control register and bus answer.
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_r <= EPC_CTL_RST[EPC_BIT_LAT];
            pg_r <= EPC_CTL_RST[EPC_BIT_PG];
        end else begin
            lat_r <= lat_nxt;
            pg_r <= pg_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 8'h00;
        end else begin
            pend_r <= req;
            ack_r <= pend_r;
            if (pend_r) begin
                dat_r <= rd_val;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !lat_r) begin
            cap_valid_r <= 1'b0;
            cap_addr_r <= 13'h0000;
            cap_data_r <= 8'h00;
        end else if (arr_wr && !cap_valid_r) begin
            cap_valid_r <= 1'b1;
            cap_addr_r <= idx;
            cap_data_r <= wb_dat_i[7:0];
        end
    end

    // ****************************************
    // Reset-time option load and boot strap capture.
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= EPC_ST_LOAD_UP;
            opt_up_r <= EPC_OPT_RST;
            opt_lo_r <= EPC_OPT_RST;
            boot_r <= EPC_BOOT_NONE;
            ext_src_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == EPC_ST_LOAD_UP) begin
                opt_up_r <= arr_rdata_i;
                ext_src_r <= !boot_source_select_i;
                unique case (boot_pat)
                    EPC_PAT_PROG: boot_r <= EPC_BOOT_PROG_VERIFY;
                    EPC_PAT_VERIFY: boot_r <= EPC_BOOT_VERIFY;
                    EPC_PAT_DUMP: boot_r <= EPC_BOOT_DUMP;
                    default: boot_r <= EPC_BOOT_NONE;
                endcase
            end
            if (st_r == EPC_ST_LOAD_LO) begin
                opt_lo_r <= arr_rdata_i;
            end
        end
    end

    // ****************************************
    // Option driven behaviour.
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_prev_r <= 1'b1;
            irq_r <= 1'b0;
            key_prev_r <= 8'hff;
            key_irq_r <= 8'h00;
            wd_r <= 1'b0;
            halt_r <= 1'b0;
            osc_stop_r <= 1'b0;
        end else begin
            irq_prev_r <= irq_n_i;
            irq_r <= irq_nxt && run;
            key_prev_r <= key_pins_i;
            key_irq_r <= run ? key_nxt : 8'h00;
            wd_r <= run && opt_lo_r[EPC_OPT_WD] && wd_timeout_i && irq_pin_normal_i;
            halt_r <= run && stop_req_i && opt_lo_r[EPC_OPT_STOP];
            osc_stop_r <= run && stop_req_i && !opt_lo_r[EPC_OPT_STOP];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            div_cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            div_cnt_r <= div_end ? 7'h00 : div_cnt_r + 7'h01;
            tick_r <= div_end;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, dat_r};
    assign prog_addr_o = cap_addr_r;
    assign prog_data_o = cap_data_r;
    assign prog_valid_o = cap_valid_r;
    assign prog_latch_o = lat_r;
    assign prog_power_o = pg_r;
    assign boot_mode_o = boot_r;
    assign boot_ext_src_o = ext_src_r;
    assign wd_reset_o = wd_r;
    assign irq_req_o = irq_r;
    assign key_pullup_options_o = opt_up_r;
    assign key_irq_o = key_irq_r;
    assign lsb_first_o = opt_lo_r[EPC_OPT_LSB_FIRST];
    assign serial_tick_o = tick_r;
    assign halt_mode_o = halt_r;
    assign osc_stop_o = osc_stop_r;
    assign secure_lock_o = opt_lo_r[EPC_OPT_SECURE];

    // ****************************************
    // Checks.
    // ****************************************
    AST_RESET_CLEAR:
        assert property (@(posedge clk_i) rst_i |=> (!prog_latch_o && !prog_power_o))
        else $error("control bits not cleared by reset");

    AST_POWER_OFF:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (ctl_wr && !wb_dat_i[EPC_BIT_PG]) |=> !prog_power_o)
        else $error("power stays on after clearing write");

    AST_POWER_NEEDS_LATCH:
        assert property (@(posedge clk_i) disable iff (rst_i)
            $rose(prog_power_o) |-> $past(prog_latch_o))
        else $error("power set without prior latch");

    AST_LATCH_DROPS_POWER:
        assert property (@(posedge clk_i) disable iff (rst_i)
            $fell(prog_latch_o) |-> !prog_power_o)
        else $error("power survives latch clear");

    AST_BOTH_SET:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (ctl_wr && !lat_r && wb_dat_i[EPC_BIT_LAT] && wb_dat_i[EPC_BIT_PG])
            |=> (prog_latch_o && !prog_power_o))
        else $error("double set did not give latch only");

    AST_CAPTURE:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (arr_wr && !cap_valid_r) |=> (prog_valid_o && prog_addr_o == $past(idx)))
        else $error("latched write target not captured");

    AST_LATCHED_READ_ZERO:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (req && !wb_we_i && is_arr && lat_r) |=> ##1 (wb_ack_o && wb_dat_o == 32'h0))
        else $error("latched array read returned data");

    AST_CTL_READBACK:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (pend_r && is_ctl && !wb_we_i) |=> (wb_dat_o[7:0] == $past(ctl_val)))
        else $error("control readback wrong");

    AST_OPT_STABLE:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (run && $past(run)) |-> $stable(opt_lo_r))
        else $error("options changed without reset");

    AST_TICK_SPACING:
        assert property (@(posedge clk_i) disable iff (rst_i || !run)
            (serial_tick_o && rate == 2'b11) |=> !serial_tick_o [*7] ##1 serial_tick_o)
        else $error("divide by 8 spacing wrong");

    AST_LATCHED_NO_STROBE:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (run && lat_r) |-> !arr_rd_o)
        else $error("array strobed while latched");

    AST_ARRAY_READ:
        assert property (@(posedge clk_i) disable iff (rst_i)
            bus_rd |=> (wb_dat_o[7:0] == $past(arr_rdata_i)))
        else $error("array read data not returned");

    AST_BOOT_PROG:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (st_r == EPC_ST_LOAD_UP && boot_pat == EPC_PAT_PROG)
            |=> (boot_mode_o == EPC_BOOT_PROG_VERIFY))
        else $error("program pattern not decoded");

    AST_WATCHDOG_OFF:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (run && !opt_lo_r[EPC_OPT_WD]) |=> !wd_reset_o)
        else $error("watchdog reset while disabled");

    AST_STOP_ONE_MODE:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (run && stop_req_i) |=> (halt_mode_o != osc_stop_o))
        else $error("stop request gave no single mode");

endmodule

// ==== sim/epc_array_model.sv ====
/* Behavioural program array facing the control block.
   Assumes the block's clock and its array read and programming ports. */
`timescale 1ns/100ps
module epc_array_model (
    input wire logic clk_i,
    input wire logic [12:0] arr_addr_i,
    input wire logic arr_rd_i,
    output logic [7:0] arr_rdata_o,
    input wire logic [12:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    input wire logic prog_valid_i,
    input wire logic prog_power_i
);
    logic [7:0] mem_r [0:8191];
    logic [7:0] last_r;
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem_r[i] = 8'(i) ^ 8'h5a;
        end
        mem_r[13'h1eff] = 8'ha5;
        mem_r[13'h1f00] = 8'h9d;
        last_r = 8'h00;
    end
    // Unread data shows the inverse of the last byte, so a stale value never matches.
    assign arr_rdata_o = arr_rd_i ? mem_r[arr_addr_i] : ~last_r;
    always @(posedge clk_i) begin
        if (arr_rd_i) begin
            last_r <= mem_r[arr_addr_i];
        end
        if (prog_power_i && prog_valid_i) begin
            mem_r[prog_addr_i] <= prog_data_i;
        end
    end
endmodule

// ==== sim/epc_top_tb.sv ====
/* Self-checking bench for the programming control and option decoder.
   Assumes the design package and the array model in its own file. */
`timescale 1ns/100ps
module epc_top_tb import epc_pkg::*;;
    typedef struct packed {logic [7:0] wr; logic [7:0] rd; logic pwr;} epc_row_t;
    localparam logic [15:2] A_CTL = {1'b0, EPC_IDX_CTL};
    localparam logic [15:2] A_ARR = {1'b0, 13'h0733};
    localparam logic [15:2] A_OPT = {1'b0, EPC_IDX_OPT_LO};
    localparam logic [15:2] A_BAD = {1'b1, EPC_IDX_CTL};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, arr_rd_o;
    logic [15:2] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [12:0] arr_addr_o, prog_addr_o;
    logic [7:0] arr_rdata_i, prog_data_o, key_pins_i, key_pullup_options_o, key_irq_o;
    logic prog_valid_o, prog_latch_o, prog_power_o, boot_ext_src_o;
    logic boot_select_high_i, boot_select_mid_i, boot_select_low_i, boot_source_select_i;
    epc_boot_t boot_mode_o;
    logic wd_timeout_i, irq_pin_normal_i, wd_reset_o, irq_n_i, irq_req_o, lsb_first_o;
    logic serial_tick_o, stop_req_i, halt_mode_o, osc_stop_o, secure_lock_o;
    int err_total = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    epc_row_t rows [9] = '{'{8'h05, 8'h04, 1'b0}, '{8'h01, 8'h00, 1'b0},
        '{8'h01, 8'h00, 1'b0}, '{8'hfe, 8'h04, 1'b0}, '{8'h05, 8'h05, 1'b1},
        '{8'hff, 8'h05, 1'b1}, '{8'h04, 8'h04, 1'b0}, '{8'h05, 8'h05, 1'b1},
        '{8'h00, 8'h00, 1'b0}};
    logic [3:0] pins [4] = '{4'hf, 4'hc, 4'h9, 4'h1};
    epc_boot_t modes [4] = '{EPC_BOOT_PROG_VERIFY, EPC_BOOT_VERIFY, EPC_BOOT_DUMP,
        EPC_BOOT_NONE};

    epc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .arr_addr_o, .arr_rd_o, .arr_rdata_i,
        .prog_addr_o, .prog_data_o, .prog_valid_o, .prog_latch_o, .prog_power_o,
        .boot_select_high_i, .boot_select_mid_i, .boot_select_low_i,
        .boot_source_select_i, .boot_mode_o, .boot_ext_src_o, .wd_timeout_i,
        .irq_pin_normal_i, .wd_reset_o, .irq_n_i, .irq_req_o, .key_pins_i,
        .key_pullup_options_o, .key_irq_o, .lsb_first_o, .serial_tick_o, .stop_req_i,
        .halt_mode_o, .osc_stop_o, .secure_lock_o);
    epc_array_model array_model (.clk_i, .arr_addr_i(arr_addr_o), .arr_rd_i(arr_rd_o),
        .arr_rdata_o(arr_rdata_i), .prog_addr_i(prog_addr_o), .prog_data_i(prog_data_o),
        .prog_valid_i(prog_valid_o), .prog_power_i(prog_power_o));

    always #2 clk_i = ~clk_i;

    task automatic complete_run();
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; it returns at the next falling edge so outputs have settled.
    task automatic wb(input logic w, input logic [15:2] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rdat = wb_dat_o;
        chk("ack", wb_ack_o, 1'b1);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(negedge clk_i);
    endtask

    task automatic rd_chk(input string name, input logic [15:2] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(name, rdat, {24'h0, e});
    endtask

    task automatic do_reset(input logic [3:0] p);
        @(posedge clk_i);
        {boot_select_high_i, boot_select_mid_i, boot_select_low_i} <= p[3:1];
        boot_source_select_i <= p[0];
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic opt_chk(input logic [7:0] lo);
        logic [6:0] div;
        int n;
        div = lo[4] ? (lo[3] ? EPC_DIV_8 : EPC_DIV_16) : (lo[3] ? EPC_DIV_32 : EPC_DIV_64);
        chk("pullups", key_pullup_options_o, 8'ha5);
        chk("lsb first", lsb_first_o, lo[2]);
        chk("secure", secure_lock_o, lo[7]);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (serial_tick_o !== 1'b1 && n < 200);
        end
        chk("tick gap", 32'(n), 32'(div));
        @(posedge clk_i);
        irq_n_i <= 1'b0;
        key_pins_i <= 8'h00;
        repeat (2) @(negedge clk_i);
        chk("irq edge", irq_req_o, 1'b1);
        chk("key edge", key_irq_o, 8'ha5);
        repeat (4) @(negedge clk_i);
        chk("irq level", irq_req_o, lo[1]);
        chk("key irq", key_irq_o, lo[1] ? 8'ha5 : 8'h00);
        @(posedge clk_i);
        irq_n_i <= 1'b1;
        key_pins_i <= 8'hff;
        {wd_timeout_i, irq_pin_normal_i, stop_req_i} <= 3'b111;
        repeat (3) @(negedge clk_i);
        chk("watchdog", wd_reset_o, lo[0]);
        chk("halt", halt_mode_o, lo[5]);
        chk("osc stop", osc_stop_o, !lo[5]);
        @(posedge clk_i);
        irq_pin_normal_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("watchdog gated", wd_reset_o, 1'b0);
        @(posedge clk_i);
        {wd_timeout_i, stop_req_i} <= 2'b00;
    endtask

    // ****************************************
    // Stimulus and checks.
    // ****************************************
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 14'h0000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0000_0000;
        {wd_timeout_i, irq_pin_normal_i, irq_n_i, stop_req_i} = 4'b0010;
        key_pins_i = 8'hff;
        {boot_select_high_i, boot_select_mid_i, boot_select_low_i} = 3'b111;
        boot_source_select_i = 1'b1;
        do_reset(4'hf);
        rd_chk("control reset", A_CTL, EPC_CTL_RST);
        chk("power reset", prog_power_o, 1'b0);
        opt_chk(8'h9d);
        foreach (rows[i]) begin
            wb(1'b1, A_CTL, rows[i].wr);
            rd_chk("control", A_CTL, rows[i].rd);
            chk("power", prog_power_o, rows[i].pwr);
            chk("latch", prog_latch_o, rows[i].rd[2]);
        end
        rd_chk("array", A_ARR, 8'h69);
        wb(1'b1, A_CTL, 8'h04);
        rd_chk("latched read", A_ARR, 8'h00);
        wb(1'b1, A_OPT, 8'h22);
        wb(1'b1, A_ARR, 8'h99);
        chk("target addr", prog_addr_o, EPC_IDX_OPT_LO);
        chk("target data", prog_data_o, 8'h22);
        chk("target valid", prog_valid_o, 1'b1);
        wb(1'b1, A_CTL, 8'h05);
        chk("power on", prog_power_o, 1'b1);
        repeat (16) @(negedge clk_i);
        wb(1'b1, A_CTL, 8'h00);
        @(negedge clk_i);
        chk("target clear", prog_valid_o, 1'b0);
        chk("old option", lsb_first_o, 1'b1);
        wb(1'b1, A_BAD, 8'h04);
        rd_chk("unmapped", A_BAD, 8'h00);
        rd_chk("control kept", A_CTL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            do_reset(pins[i]);
            chk("boot", boot_mode_o, modes[i]);
            chk("ext src", boot_ext_src_o, !pins[i][0]);
        end
        opt_chk(8'h22);
        complete_run();
    end
endmodule
